// ==== hdl/ebc_consts.vh ====
`ifndef EBC_CONSTS_VH
`define EBC_CONSTS_VH
// Transfer size codes
`define EBC_SIZE_LONG    2'b00
`define EBC_SIZE_BYTE    2'b01
`define EBC_SIZE_WORD    2'b10
`define EBC_SIZE_LINE    2'b11
// Access class codes
`define EBC_CLASS_NORMAL 2'b00
`define EBC_CLASS_DMA    2'b01
`define EBC_CLASS_DEBUG  2'b10
`define EBC_CLASS_CPU    2'b11
// Timing
`define EBC_CLK_PERIOD_NS 10
`define EBC_DRAM_ACC_NS   40
// DRAM access rounded up to whole clocks
`define EBC_DRAM_CYC     4'd4
`define EBC_CAS_LAST     4'd2
// Request word layout
`define EBC_RQ_WIDTH     41
`define EBC_RQ_DEPTH     4
`define EBC_RQ_WRITE     40
`define EBC_RQ_SIZE_HI   39
`define EBC_RQ_SIZE_LO   38
`define EBC_RQ_CLASS_HI  37
`define EBC_RQ_CLASS_LO  36
`define EBC_RQ_CODE      35
`define EBC_RQ_SUPER     34
`define EBC_RQ_DRAM      33
`define EBC_RQ_BANK      32
`endif

// ==== hdl/ebc_bus_ctrl.v ====
// Function
// - Every write drives all 32 data lines regardless of port or operand size.
// - Transfer start is asserted for exactly one clock at each mastered cycle.
// - Under an external master, watch start, direction and size to act.
// - Direction high means read, low means write, for any master.
// - Size code 00 longword, 01 byte, 10 word, 11 sixteen-byte line.
// - Access class 00 normal, 01 DMA, 10 debug, 11 CPU space.
// - Access class and mode hint are outputs only, never sampled.
// - Mode hint has two phases: during start strobe and after it.
// - Async acknowledge is synchronised before use; slave holds it 1.5 clocks.
// - Async read data captured at synced ack edge; write data held till falling edge.
// - DRAM cycles ignore async and error acks; own DRAM cycles ignore sync ack.
// - External cycle to chip-select region: sync ack after wait states if auto-ack.
// - External cycle to DRAM bank: drive sync ack when DRAM transfer completes.
// - Error acknowledge aborts the cycle at once and beats both other acks.
// - Error acknowledge up to one clock after async ack still ends in error.
// - Double bus fault halts mastered cycles until reset; external master cycles are still answered.
// - Bus outputs change on rising edges; row and column strobes and data output enable on falling edges.
// - Interrupt level, reset input and async ack pass through synchronisers.
// - Driven sync ack is driven negated one clock before release.
`include "ebc_consts.vh"

// ****************************************
// Request FIFO
// ****************************************
module ebc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output reg              in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push = in_valid & in_ready;
  wire            pop  = out_valid & out_ready;
  wire [AW:0]     next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign out_data  = mem[rd_ptr];
  assign out_valid = (count != {(AW+1){1'b0}});

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
    if (sys_rst) begin
      wr_ptr   <= {AW{1'b0}};
      rd_ptr   <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      count    <= next_count;
      in_ready <= (next_count != DEPTH[AW:0]);
    end
  end
endmodule

// ****************************************
// Bus control
// ****************************************
module ebc_bus_ctrl (
  input  wire                     clk,
  input  wire                     sys_rst,
  input  wire [`EBC_RQ_WIDTH-1:0] req_word,
  input  wire                     req_valid,
  output wire                     req_ready,
  output reg                      done,
  output reg                      done_err,
  output reg  [31:0]              rd_data,
  output reg                      halted,
  input  wire                     fault_clear,
  output reg                      fault_pending,
  input  wire                     ts_in_n,
  output reg                      ts_out_n,
  input  wire                     rw_in,
  output reg                      rw_out,
  input  wire [1:0]               size_in,
  output reg  [1:0]               size_out,
  output reg  [1:0]               access_class,
  output reg                      access_mode_hint,
  output reg                      master_oe_n,
  input  wire [31:0]              d_in,
  output reg  [31:0]              d_out,
  output reg                      d_oe_n,
  input  wire                     sync_ack_in_n,
  output reg                      sync_ack_out_n,
  output reg                      sync_ack_oe_n,
  input  wire                     async_ack_n,
  input  wire                     error_ack_n,
  output reg  [1:0]               row_strobe_n,
  output reg  [3:0]               column_strobe_n,
  input  wire                     ext_owns,
  input  wire                     ext_hit_cs,
  input  wire                     ext_hit_dram,
  input  wire                     ext_bank,
  input  wire [3:0]               ext_wait_states,
  input  wire                     ext_master_auto_ack,
  output reg                      ext_cs_n,
  output reg                      ext_read,
  output reg  [1:0]               ext_size,
  input  wire [2:0]               interrupt_level_in,
  output reg  [2:0]               int_level_sync,
  input  wire                     reset_input_pin,
  output reg                      reset_in_sync
);
  localparam M_IDLE  = 3'd0;
  localparam M_START = 3'd1;
  localparam M_WAIT  = 3'd2;
  localparam M_AWIN  = 3'd3;
  localparam M_HALT  = 3'd4;
  localparam X_IDLE  = 2'd0;
  localparam X_WAIT  = 2'd1;
  localparam X_ACK   = 2'd2;
  localparam X_NEG   = 2'd3;

  // Mode hint for a given phase
  function atm_bit;
    input [1:0] cls;
    input       code;
    input       sup;
    input       after_start;
    begin
      case (cls)
        `EBC_CLASS_NORMAL: atm_bit = after_start ? sup : code;
        `EBC_CLASS_DEBUG:  atm_bit = after_start ? sup : code;
        `EBC_CLASS_DMA:    atm_bit = ~after_start;
        default:           atm_bit = code & ~after_start;
      endcase
    end
  endfunction

  wire [`EBC_RQ_WIDTH-1:0] f_word;
  wire                     f_valid;
  reg  [2:0]               mst;
  reg  [1:0]               xst;
  reg  [`EBC_RQ_WIDTH-1:0] cur;
  reg  [3:0]               mcnt;
  reg  [3:0]               xcnt;
  reg                      xdram;
  reg                      xbank;
  reg                      drive_wr;
  reg                      ata_s1;
  reg                      ata_s2;
  reg  [2:0]               ipl_s1;
  reg                      reset_input_pin_s1;

  wire f_pop    = (mst == M_IDLE) & f_valid & ~ext_owns;
  wire cur_dram = cur[`EBC_RQ_DRAM];
  wire cur_rd   = ~cur[`EBC_RQ_WRITE];
  wire error_ack      = ~error_ack_n;
  wire m_err    = ((mst == M_WAIT) & ~cur_dram & error_ack) | ((mst == M_AWIN) & error_ack);
  wire m_dram_done = (mst == M_WAIT) & cur_dram & (mcnt == 4'd1);
  wire m_ta     = (mst == M_WAIT) & ~cur_dram & ~sync_ack_in_n;
  wire m_ata    = (mst == M_WAIT) & ~cur_dram & ata_s2;
  wire m_ok     = ~m_err & (m_dram_done | m_ta | ((mst == M_AWIN) & ~error_ack));
  wire m_dram_act = (mst == M_WAIT) & cur_dram;
  wire x_dram_act = (xst == X_WAIT) & xdram;
  wire cas_phase  = m_dram_act ? (mcnt <= `EBC_CAS_LAST) : (xcnt < `EBC_CAS_LAST);
  wire strobe_bank = m_dram_act ? cur[`EBC_RQ_BANK] : xbank;
  wire ext_start  = ext_owns & ~ts_in_n & (xst == X_IDLE);

  ebc_fifo #(
    .WIDTH (`EBC_RQ_WIDTH),
    .DEPTH (`EBC_RQ_DEPTH),
    .AW    (2)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_data   (req_word),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .out_data  (f_word),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // ****************************************
  // Synchronisers
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      ata_s1         <= 1'b0;
      ata_s2         <= 1'b0;
      ipl_s1         <= 3'h7;
      int_level_sync <= 3'h7;
      reset_input_pin_s1        <= 1'b1;
      reset_in_sync  <= 1'b1;
    end else begin
      ata_s1         <= ~async_ack_n;
      ata_s2         <= ata_s1;
      ipl_s1         <= interrupt_level_in;
      int_level_sync <= ipl_s1;
      reset_input_pin_s1        <= reset_input_pin;
      reset_in_sync  <= reset_input_pin_s1;
    end
  end

  // ****************************************
  // Master cycles
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      mst              <= M_IDLE;
      cur              <= {`EBC_RQ_WIDTH{1'b0}};
      mcnt             <= 4'h0;
      ts_out_n         <= 1'b1;
      rw_out           <= 1'b1;
      size_out         <= `EBC_SIZE_LONG;
      access_class     <= `EBC_CLASS_NORMAL;
      access_mode_hint <= 1'b0;
      master_oe_n      <= 1'b1;
      d_out            <= 32'h0000_0000;
      drive_wr         <= 1'b0;
      rd_data          <= 32'h0000_0000;
      done             <= 1'b0;
      done_err         <= 1'b0;
      halted           <= 1'b0;
      fault_pending    <= 1'b0;
    end else begin
      done     <= m_ok | m_err;
      done_err <= m_err;
      if (fault_clear & ~m_err) begin
        fault_pending <= 1'b0;
      end
      case (mst)
        M_IDLE: begin
          if (f_pop) begin
            cur              <= f_word;
            ts_out_n         <= 1'b0;
            master_oe_n      <= 1'b0;
            rw_out           <= ~f_word[`EBC_RQ_WRITE];
            size_out         <= f_word[`EBC_RQ_SIZE_HI:`EBC_RQ_SIZE_LO];
            access_class     <= f_word[`EBC_RQ_CLASS_HI:`EBC_RQ_CLASS_LO];
            access_mode_hint <= atm_bit(f_word[`EBC_RQ_CLASS_HI:`EBC_RQ_CLASS_LO],
                                        f_word[`EBC_RQ_CODE], f_word[`EBC_RQ_SUPER], 1'b0);
            d_out            <= f_word[31:0];
            drive_wr         <= f_word[`EBC_RQ_WRITE];
            mst              <= M_START;
          end
        end
        M_START: begin
          ts_out_n         <= 1'b1;
          access_mode_hint <= atm_bit(cur[`EBC_RQ_CLASS_HI:`EBC_RQ_CLASS_LO],
                                      cur[`EBC_RQ_CODE], cur[`EBC_RQ_SUPER], 1'b1);
          mcnt             <= `EBC_DRAM_CYC;
          mst              <= M_WAIT;
        end
        M_WAIT: begin
          mcnt <= mcnt - 4'h1;
          if (m_ata & ~error_ack) begin
            mst <= M_AWIN;
          end
          if ((m_ta | m_ata | m_dram_done) & ~m_err & cur_rd) begin
            rd_data <= d_in;
          end
        end
        M_AWIN: begin
          mst <= M_IDLE;
        end
        M_HALT: begin
          mst <= M_HALT;
        end
        default: begin
          mst <= M_IDLE;
        end
      endcase
      if (m_ok | m_err) begin
        master_oe_n <= 1'b1;
        drive_wr    <= 1'b0;
        mst         <= M_IDLE;
      end
      if (m_err) begin
        fault_pending <= 1'b1;
        if (fault_pending) begin
          halted <= 1'b1;
          mst    <= M_HALT;
        end
      end
    end
  end

  // ****************************************
  // External master cycles
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      xst            <= X_IDLE;
      xcnt           <= 4'h0;
      xdram          <= 1'b0;
      xbank          <= 1'b0;
      ext_cs_n       <= 1'b1;
      ext_read       <= 1'b1;
      ext_size       <= `EBC_SIZE_LONG;
      sync_ack_out_n <= 1'b1;
      sync_ack_oe_n  <= 1'b1;
    end else begin
      case (xst)
        X_IDLE: begin
          if (ext_start) begin
            ext_read <= rw_in;
            ext_size <= size_in;
            xbank    <= ext_bank;
            if (ext_hit_dram) begin
              xdram <= 1'b1;
              xcnt  <= `EBC_DRAM_CYC - 4'd1;
              xst   <= X_WAIT;
            end else if (ext_hit_cs) begin
              xdram    <= 1'b0;
              ext_cs_n <= 1'b0;
              xcnt     <= ext_wait_states;
              if (ext_master_auto_ack) begin
                xst <= X_WAIT;
              end
            end
          end else if (~ext_owns | ~ts_in_n) begin
            ext_cs_n <= 1'b1;
          end
        end
        X_WAIT: begin
          if (xcnt == 4'h0) begin
            sync_ack_out_n <= 1'b0;
            sync_ack_oe_n  <= 1'b0;
            xst            <= X_ACK;
          end else begin
            xcnt <= xcnt - 4'h1;
          end
        end
        X_ACK: begin
          sync_ack_out_n <= 1'b1;
          ext_cs_n       <= 1'b1;
          xdram          <= 1'b0;
          xst            <= X_NEG;
        end
        X_NEG: begin
          sync_ack_oe_n <= 1'b1;
          xst           <= X_IDLE;
        end
        default: begin
          xst <= X_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Falling-edge strobes and data release
  // ****************************************
  always @(negedge clk) begin
    if (sys_rst) begin
      row_strobe_n    <= 2'b11;
      column_strobe_n <= 4'hf;
      d_oe_n          <= 1'b1;
    end else begin
      row_strobe_n    <= (m_dram_act | x_dram_act) ? {~strobe_bank, strobe_bank} : 2'b11;
      column_strobe_n <= ((m_dram_act | x_dram_act) & cas_phase) ? 4'h0 : 4'hf;
      d_oe_n          <= ~drive_wr;
    end
  end
endmodule

// ==== testbench/ebc_bus_ctrl_monitor.sv ====
// ****************************************
// Bus control checker
// ****************************************
module ebc_bus_ctrl_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       ts_out_n,
  input wire logic       rw_out,
  input wire logic       d_oe_n,
  input wire logic       master_oe_n,
  input wire logic       error_ack_n,
  input wire logic       done,
  input wire logic       done_err,
  input wire logic       halted,
  input wire logic [1:0] row_strobe_n,
  input wire logic [1:0] access_class,
  input wire logic       access_mode_hint,
  input wire logic       sync_ack_out_n,
  input wire logic       sync_ack_oe_n,
  input wire logic [2:0] interrupt_level_in,
  input wire logic [2:0] int_level_sync,
  input wire logic       reset_input_pin,
  input wire logic       reset_in_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_start_one_clk: assert property ($fell(ts_out_n) |=> ts_out_n)
    else $error("start strobe held too long");
  a_write_drives_bus: assert property (!ts_out_n && !rw_out |=> !d_oe_n)
    else $error("write cycle left data undriven");
  a_dma_hint_phases: assert property ($fell(ts_out_n) && access_class == 2'h1 |->
    access_mode_hint ##1 !access_mode_hint)
    else $error("dma hint phases wrong");
  a_error_aborts: assert property (ts_out_n && !master_oe_n && !done && &row_strobe_n && !error_ack_n |=>
    done && done_err)
    else $error("error acknowledge did not abort");
  a_err_with_done: assert property (done_err |-> done)
    else $error("error flag without done");
  a_halt_sticky: assert property (halted |=> halted && ts_out_n)
    else $error("halt left or cycle started");
  a_ack_one_clk: assert property ($fell(sync_ack_out_n) |->
    !sync_ack_oe_n ##1 sync_ack_out_n && !sync_ack_oe_n)
    else $error("driven acknowledge not one clock");
  a_ack_release: assert property ($rose(sync_ack_oe_n) |->
    $past(sync_ack_out_n) && !$past(sync_ack_oe_n, 2))
    else $error("acknowledge released without negated clock");
  a_level_sync: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
    int_level_sync == $past(interrupt_level_in, 2))
    else $error("level synchroniser depth wrong");
  a_reset_sync: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
    reset_in_sync == $past(reset_input_pin, 2))
    else $error("reset input synchroniser depth wrong");
endmodule

bind ebc_bus_ctrl ebc_bus_ctrl_monitor mon (.clk, .sys_rst, .ts_out_n, .rw_out, .d_oe_n, .master_oe_n, .error_ack_n,
  .done, .done_err, .halted, .row_strobe_n, .access_class, .access_mode_hint, .sync_ack_out_n, .sync_ack_oe_n,
  .interrupt_level_in, .int_level_sync, .reset_input_pin, .reset_in_sync);

// ==== testbench/ebc_slave_model.sv ====
// ****************************************
// Slave answering mastered cycles
// ****************************************
module ebc_slave_model (
  input wire logic        clk,
  input wire logic        ts_out_n,
  input wire logic        master_oe_n,
  input wire logic [31:0] d_out,
  input wire logic [1:0]  mode,
  input wire logic [3:0]  dly,
  input wire logic [31:0] rd_val,
  output logic            sync_ack_in_n,
  output logic            async_ack_n,
  output logic            error_ack_n,
  output logic [31:0]     d_in,
  output logic [31:0]     wr_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {sync_ack_in_n, async_ack_n, error_ack_n} = 3'h7;
    d_in = 32'h0;
    wr_seen = 32'h0;
  end
  // Mode 0 sync, 1 async, 2 error, 3 async then error
  always @(posedge clk) if (!ts_out_n) begin
    repeat (dly) @(posedge clk);
    #1 d_in = rd_val;
    wr_seen = d_out;
    sync_ack_in_n = (mode != 2'h0);
    async_ack_n = !mode[0];
    error_ack_n = (mode != 2'h2);
    if (mode == 2'h3) begin
      @(posedge clk);
      #1 error_ack_n = 1'b0;
    end
    repeat (2) @(posedge clk);
    while (!master_oe_n) @(posedge clk);
    #1 {sync_ack_in_n, async_ack_n, error_ack_n} = 3'h7;
    d_in = ~rd_val;
  end
endmodule

// ==== testbench/ebc_bus_ctrl_tb.sv ====
`include "ebc_consts.vh"
module ebc_bus_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [1:0] sz, cls; logic code, sup, dram; logic [1:0] md; logic err, h1, h2;} ebc_row_t;
  logic                     clk, sys_rst, req_valid, fault_clear, ts_in_n, rw_in, ext_owns, ext_hit_cs;
  logic                     ext_hit_dram, ext_bank, ext_master_auto_ack, reset_input_pin;
  logic                     req_ready, done, done_err, halted, fault_pending, ts_out_n, rw_out, access_mode_hint;
  logic                     master_oe_n, d_oe_n, sync_ack_in_n, sync_ack_out_n, sync_ack_oe_n, async_ack_n;
  logic                     error_ack_n, ext_cs_n, ext_read, reset_in_sync;
  logic [`EBC_RQ_WIDTH-1:0] req_word;
  logic [1:0]               size_in, mode, size_out, access_class, row_strobe_n, ext_size;
  logic [3:0]               ext_wait_states, dly, column_strobe_n;
  logic [2:0]               interrupt_level_in, int_level_sync;
  logic [31:0]              rd_val, d_in, wr_seen, rd_data, d_out;
  int                       miscompares, n_checks;
  ebc_row_t                 r;
  ebc_row_t rows [8] = '{'{0,0,0,1,1,0,0,0,1,1}, '{1,1,1,0,0,0,1,0,1,0}, '{0,2,2,0,1,0,1,0,0,1},
    '{1,3,3,1,0,0,0,0,1,0}, '{0,0,3,0,0,0,2,1,0,0}, '{1,0,0,0,0,0,3,1,0,0}, '{0,0,0,1,1,1,2,0,1,1},
    '{1,0,0,1,0,0,0,0,1,0}};

  ebc_bus_ctrl uut (.clk, .sys_rst, .req_word, .req_valid, .req_ready, .done, .done_err, .rd_data, .halted,
    .fault_clear, .fault_pending, .ts_in_n, .ts_out_n, .rw_in, .rw_out, .size_in, .size_out, .access_class,
    .access_mode_hint, .master_oe_n, .d_in, .d_out, .d_oe_n, .sync_ack_in_n, .sync_ack_out_n, .sync_ack_oe_n,
    .async_ack_n, .error_ack_n, .row_strobe_n, .column_strobe_n, .ext_owns, .ext_hit_cs, .ext_hit_dram, .ext_bank,
    .ext_wait_states, .ext_master_auto_ack, .ext_cs_n, .ext_read, .ext_size, .interrupt_level_in,
    .int_level_sync, .reset_input_pin, .reset_in_sync);
  ebc_slave_model slave (.clk, .ts_out_n, .master_oe_n, .d_out, .mode, .dly, .rd_val, .sync_ack_in_n,
    .async_ack_n, .error_ack_n, .d_in, .wr_seen);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) interrupt_level_in <= sys_rst ? 3'h0 : interrupt_level_in + 3'h1;
  always @(negedge clk) reset_input_pin <= interrupt_level_in[1];

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic await(ref logic s, input logic v);
    for (int k = 0; k < 60 && s !== v; k++) @(negedge clk);
    chk(s, v);
  endtask
  task automatic push(input logic [`EBC_RQ_WIDTH-1:0] w);
    req_word = w;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk) req_valid = 1'b0;
    @(negedge clk);
  endtask
  task automatic do_reset;
    sys_rst = 1'b1;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
  endtask
  task automatic ext_cycle(input logic cs);
    {ext_hit_cs, ext_hit_dram, ts_in_n, rw_in, size_in} = {cs, !cs, 1'b0, 1'b1, 2'h2};
    @(negedge clk) ts_in_n = 1'b1;
    if (cs) await(ext_cs_n, 1'b0);
    if (cs) chk({ext_read, ext_size}, 32'h6);
    await(sync_ack_out_n, 1'b0);
    await(sync_ack_oe_n, 1'b1);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100us;
    $display("watchdog expired");
    miscompares++;
    stop_test();
  end

  initial begin
    {req_valid, fault_clear, ts_in_n, rw_in, ext_owns, ext_hit_cs, ext_hit_dram, ext_bank} = 8'h20;
    {ext_master_auto_ack, reset_input_pin, req_word, size_in, mode, ext_wait_states, dly} = '0;
    {interrupt_level_in, rd_val} = '0;
    do_reset();
    chk({req_ready, halted, ts_out_n, master_oe_n, d_oe_n, sync_ack_oe_n}, 32'h2f);
    $display("test reset done");
    // ****************************************
    // Table of mastered cycles
    // ****************************************
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      mode = r.md;
      dly = 4'(i % 4);
      rd_val = {16'hc3c3, 16'(i)};
      push({r.wr, r.sz, r.cls, r.code, r.sup, r.dram, 1'b0, rd_val});
      await(ts_out_n, 1'b0);
      chk({rw_out, size_out, access_class}, {27'h0, !r.wr, r.sz, r.cls});
      chk(access_mode_hint, r.h1);
      @(negedge clk);
      chk(access_mode_hint, r.h2);
      if (r.dram) begin
        @(posedge clk) chk({row_strobe_n, column_strobe_n}, 32'h2f);
        repeat (3) @(posedge clk);
        chk({row_strobe_n, column_strobe_n}, 32'h20);
      end
      await(done, 1'b1);
      chk({done_err, fault_pending}, {30'h0, r.err, r.err});
      if (!r.err) chk(r.wr ? wr_seen : rd_data, rd_val);
      fault_clear = 1'b1;
      @(negedge clk) fault_clear = 1'b0;
    end
    $display("test table done");
    // Queue fills while an external master owns the bus
    mode = 2'h0;
    ext_owns = 1'b1;
    repeat (4) push({9'h100, 32'h5a5a0f0f});
    chk(req_ready, 1'b0);
    ext_master_auto_ack = 1'b1;
    ext_wait_states = 4'h2;
    ext_cycle(1'b1);
    ext_cycle(1'b0);
    chk(ts_out_n, 1'b1);
    ext_owns = 1'b0;
    repeat (4) begin
      await(done, 1'b1);
      @(negedge clk);
    end
    chk(req_ready, 1'b1);
    chk(wr_seen, 32'h5a5a0f0f);
    $display("test queue and external done");
    // Double fault halts until reset
    mode = 2'h2;
    repeat (2) begin
      push('0);
      await(done, 1'b1);
      @(negedge clk);
    end
    chk(halted, 1'b1);
    push('0);
    repeat (20) @(negedge clk) chk(ts_out_n, 1'b1);
    do_reset();
    chk(halted, 1'b0);
    chk({req_ready, halted, ts_out_n, master_oe_n, d_oe_n, sync_ack_oe_n}, 32'h2f);
    $display("test halt done");
    stop_test();
  end
endmodule
